// [sep_slave.sv]
// Behaviour
// - Word address byte loads the pointer.
// - Ack word and data; program on stop.
// - Ignore the bus during a write cycle.
// - Page write takes up to sixteen bytes.
// - Ack every received page data byte unless protected.
// - Pointer advances after each data byte.
// - Extra page bytes wrap and overwrite.
// - Short pages program only received bytes.
// - Withhold address ack while programming.
// - Protected: ack addresses, refuse data, no programming.
// - Unprotected: every location is writable.
// - Pointer holds last address plus one; writes wrap it within the page.
// - Read address acked, then eight bits.
// - After nack stop driving, await stop.
// - Sequential read starts like other reads.
// - Each master ack sends next byte.
// - Read pointer wraps over whole array.
// - Respond only when chip select bits match.
// - Address bit zero selects read or write.
// - Bytes travel most significant bit first.
module sep_slave #(
    parameter int WRITE_CYCLES = sep_pkg::WR_CYCLES,
    parameter int FIFO_DEPTH   = sep_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        write_protect,
    input  wire logic        chip_select_bit0,
    input  wire logic        chip_select_bit1,
    input  wire logic        chip_select_bit2,
    output logic [7:0]       mem_rd_addr,
    input  wire logic [7:0]  mem_rd_data,
    output logic             prog_valid,
    input  wire logic        prog_ready,
    output logic [7:0]       prog_addr,
    output logic [7:0]       prog_data,
    output logic             busy
);

    // Width of the write cycle timer; it must be able to hold WRITE_CYCLES itself.
    localparam int TW = $clog2(WRITE_CYCLES + 1);

    // Every flop of the engine lives in this one record.
    // The page buffer and its byte mask gather data bytes until the stop.
    // The mask also tells the drain which slots arrived, so a short page
    // never touches addresses that the master did not send.
    typedef struct packed {
        sep_pkg::sep_state_type st;
        sep_pkg::sep_kind_type  kind;
        logic                   scl_prev;
        logic                   sda_prev;
        logic [7:0]             shift;
        logic [3:0]             cnt;
        logic                   rd_dir;
        logic                   ack_seen;
        logic [7:0]             ptr;
        logic [15:0]            mask;
        logic [15:0][7:0]       page;
        logic [3:0]             idx;
        logic [TW-1:0]          timer;
        logic                   drive;
    } sep_slave_state_type;

    sep_slave_state_type q;
    sep_slave_state_type d;

    // Raw and synchronised pin levels.
    logic [5:0]  pins;
    logic [5:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        wp_s;
    logic [2:0]  cs_s;

    // Bus events decoded from the synchronised levels.
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;

    // Handshake between the page drain and the request FIFO.
    logic        push_valid;
    logic        push_ready;
    logic [15:0] push_data;
    logic        fifo_valid;
    logic [15:0] fifo_data;

    // True when a received address byte selects this device.
    // The direction bit is left out; it is kept on its own once an address matches.
    function automatic logic addr_match(
        input logic [7:0] addr_byte,
        input logic [2:0] cs
    );
        addr_match = (addr_byte[7:4] == sep_pkg::DEV_TYPE_ID) &&
                     (addr_byte[3:1] == cs);
    endfunction : addr_match

    // All pins come from outside the clock domain.
    assign pins[sep_pkg::PIN_SCL] = scl;
    assign pins[sep_pkg::PIN_SDA] = sda_i;
    assign pins[sep_pkg::PIN_WP]  = write_protect;
    assign pins[sep_pkg::PIN_CS0] = chip_select_bit0;
    assign pins[sep_pkg::PIN_CS1] = chip_select_bit1;
    assign pins[sep_pkg::PIN_CS2] = chip_select_bit2;

    // Two flops per pin, so every bus event below is seen about two clocks late.
    sep_sync #(
        .WIDTH     (sep_pkg::PIN_W),
        .RESET_VAL (sep_pkg::PIN_RESET)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .pin  (pins),
        .sync (pins_s)
    );

    assign scl_s = pins_s[sep_pkg::PIN_SCL];
    assign sda_s = pins_s[sep_pkg::PIN_SDA];
    assign wp_s  = pins_s[sep_pkg::PIN_WP];
    assign cs_s  = {pins_s[sep_pkg::PIN_CS2],
                    pins_s[sep_pkg::PIN_CS1],
                    pins_s[sep_pkg::PIN_CS0]};

    // Bus events seen against the previous synchronised levels.
    // A start or stop needs the clock high in both samples, so a data change
    // that lands together with a clock edge counts as a data bit, never a condition.
    assign scl_rise = scl_s & ~q.scl_prev;
    assign scl_fall = ~scl_s & q.scl_prev;
    assign start_c  = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    assign stop_c   = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

    // Programming requests queue here so the array side may stall.
    // Each entry carries the page, the slot and the byte, sixteen bits in all.
    sep_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (fifo_valid),
        .out_ready (prog_ready),
        .out_data  (fifo_data)
    );

    // Protocol engine next-state logic.
    always_comb begin
        d          = q;
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        push_valid = 1'b0;
        push_data  = {q.ptr[7:4], q.idx, q.page[q.idx]};
        // A running write cycle shuts the bus out entirely. Otherwise a start or
        // stop overrides whatever byte was in progress, and only then does the
        // current state advance on clock edges.
        if (q.st == sep_pkg::ST_PROG) begin
            // Bus is not looked at; pending bytes drain to the array.
            // The timer runs its full length even when the array takes bytes at once.
            d.drive = 1'b0;
            if (q.timer != '0) begin
                d.timer = q.timer - 1'b1;
            end
            if (q.mask[q.idx]) begin
                push_valid = 1'b1;
                if (push_ready) begin
                    d.mask[q.idx] = 1'b0;
                    d.idx         = q.idx + 1'b1;
                end
            end else begin
                d.idx = q.idx + 1'b1;
            end
            if (q.timer == '0 && q.mask == '0 && !fifo_valid) begin
                d.st = sep_pkg::ST_IDLE;
            end
        end else if (start_c) begin
            // A start or repeated start drops any unfinished page.
            d.st    = sep_pkg::ST_RX;
            d.kind  = sep_pkg::KIND_ADDR;
            d.cnt   = '0;
            d.drive = 1'b0;
            d.mask  = '0;
        end else if (stop_c) begin
            // A stop with accepted bytes launches the write cycle; any other stop rests.
            d.drive = 1'b0;
            d.cnt   = '0;
            if (q.mask != '0) begin
                d.st    = sep_pkg::ST_PROG;
                d.timer = TW'(WRITE_CYCLES);
                d.idx   = '0;
            end else begin
                d.st = sep_pkg::ST_IDLE;
            end
        end else begin
            case (q.st)
                // Shift in eight bits on rising clock edges, then decide on the ack.
                sep_pkg::ST_RX: begin
                    if (scl_rise && q.cnt < 4'h8) begin
                        d.shift = {q.shift[6:0], sda_s};
                        d.cnt   = q.cnt + 1'b1;
                    end else if (scl_fall && q.cnt == 4'h8) begin
                        d.st    = sep_pkg::ST_ACK;
                        d.drive = 1'b1;
                        case (q.kind)
                            sep_pkg::KIND_ADDR: begin
                                if (addr_match(q.shift, cs_s)) begin
                                    d.rd_dir = q.shift[0];
                                end else begin
                                    d.st    = sep_pkg::ST_IGNORE;
                                    d.drive = 1'b0;
                                end
                            end
                            sep_pkg::KIND_WORD: begin
                                // A new word address starts an empty page.
                                d.ptr  = q.shift;
                                d.mask = '0;
                            end
                            default: begin
                                if (wp_s) begin
                                    d.st    = sep_pkg::ST_IGNORE;
                                    d.drive = 1'b0;
                                    d.mask  = '0;
                                end else begin
                                    // Low nibble wraps inside the page.
                                    d.page[q.ptr[3:0]] = q.shift;
                                    d.mask[q.ptr[3:0]] = 1'b1;
                                    d.ptr = {q.ptr[7:4], q.ptr[3:0] + 4'h1};
                                end
                            end
                        endcase
                    end
                end

                // Hold the ack through the ninth clock; its falling edge moves on.
                sep_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        d.cnt = '0;
                        if (q.kind == sep_pkg::KIND_ADDR && q.rd_dir) begin
                            // First read byte comes from the pointer.
                            d.st    = sep_pkg::ST_TX;
                            d.shift = mem_rd_data;
                            d.ptr   = q.ptr + 1'b1;
                            d.drive = ~mem_rd_data[7];
                        end else begin
                            // An address is followed by the word address, that by data.
                            d.st    = sep_pkg::ST_RX;
                            d.drive = 1'b0;
                            d.kind  = (q.kind == sep_pkg::KIND_ADDR) ?
                                      sep_pkg::KIND_WORD : sep_pkg::KIND_DATA;
                        end
                    end
                end

                // Each falling edge puts the next bit out, most significant first.
                sep_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == 4'h7) begin
                            // After the eighth bit the line is freed for the master's ack.
                            d.st       = sep_pkg::ST_RACK;
                            d.drive    = 1'b0;
                            d.cnt      = '0;
                            d.ack_seen = 1'b0;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.cnt   = q.cnt + 1'b1;
                            d.drive = ~q.shift[6];
                        end
                    end
                end

                // Look at the master's ack on the ninth rising edge.
                sep_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        d.ack_seen = ~sda_s;
                    end else if (scl_fall) begin
                        if (q.ack_seen) begin
                            d.st    = sep_pkg::ST_TX;
                            d.shift = mem_rd_data;
                            d.ptr   = q.ptr + 1'b1;
                            d.drive = ~mem_rd_data[7];
                        end else begin
                            // No ack: stay off the line until the stop.
                            d.st = sep_pkg::ST_IGNORE;
                        end
                    end
                end

                // Not addressed, refused or finished: wait for a start or stop.
                sep_pkg::ST_IGNORE: begin
                    d.drive = 1'b0;
                end

                // Bus free: nothing happens until a start.
                sep_pkg::ST_IDLE: begin
                    d.drive = 1'b0;
                end

                // Unknown code: recover to idle with the line released.
                default: begin
                    d.st    = sep_pkg::ST_IDLE;
                    d.drive = 1'b0;
                end
            endcase
        end
    end

    // State register with synchronous reset.
    // The previous bus levels reset high, as on an idle bus, so no false edge follows.
    always_ff @(posedge clk) begin
        if (srst) begin
            q          <= '0;
            q.st       <= sep_pkg::ST_IDLE;
            q.kind     <= sep_pkg::KIND_ADDR;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Open-drain data pin: only ever pulls low.
    assign sda_o       = 1'b0;
    assign sda_oe      = q.drive;

    // The array is read at the pointer itself, so the next byte is ready
    // as soon as the current one has been loaded into the shifter.
    assign mem_rd_addr = q.ptr;
    assign prog_valid  = fifo_valid;
    assign prog_addr   = fifo_data[15:8];
    assign prog_data   = fifo_data[7:0];
    assign busy        = (q.st == sep_pkg::ST_PROG);

endmodule : sep_slave

// [sep_pkg.sv]
package sep_pkg;

    // System clock period and the longest internal write cycle time.
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_WR_MS       = 5;
    localparam int WR_CYCLES     = T_WR_MS * 1000000 / CLK_PERIOD_NS;

    // Page geometry and word address width.
    localparam int ADDR_W     = 8;
    localparam int PAGE_BYTES = 16;
    localparam int FIFO_DEPTH = 4;

    // Type identifier of the slave address; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE_ID = 4'h5;

    // Positions of the pins inside the synchronised pin vector.
    localparam int PIN_SCL  = 0;
    localparam int PIN_SDA  = 1;
    localparam int PIN_WP   = 2;
    localparam int PIN_CS0  = 3;
    localparam int PIN_CS1  = 4;
    localparam int PIN_CS2  = 5;
    localparam int PIN_W    = 6;

    // Pin vector value held during reset: idle bus lines high.
    localparam logic [5:0] PIN_RESET = 6'h03;

    // Protocol engine states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_RX     = 7'h02,
        ST_ACK    = 7'h04,
        ST_TX     = 7'h08,
        ST_RACK   = 7'h10,
        ST_IGNORE = 7'h20,
        ST_PROG   = 7'h40
    } sep_state_type;

    // Meaning of the byte being received.
    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_WORD = 2'h1,
        KIND_DATA = 2'h2
    } sep_kind_type;

endpackage : sep_pkg

// [sep_sync.sv]
// Two-flop synchroniser for a vector of asynchronous pins.
module sep_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [5:0] RESET_VAL = 6'h00
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] sync
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sep_sync_state_type;

    sep_sync_state_type q;
    sep_sync_state_type d;

    // The first stage feeds only the second stage.
    always_comb begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;
    end

    // State register with synchronous reset to idle levels.
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= {RESET_VAL[WIDTH-1:0], RESET_VAL[WIDTH-1:0]};
        end else begin
            q <= d;
        end
    end

    assign sync = q.s2;

endmodule : sep_sync

// [sep_fifo.sv]
// Small FIFO with valid and ready on both sides.
module sep_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [PW:0]                 count;
    } sep_fifo_state_type;

    sep_fifo_state_type q;
    sep_fifo_state_type d;
    logic               push;
    logic               pop;

    assign in_ready  = (q.count != (PW+1)'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer wrap and occupancy count.
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        end
        d.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : sep_fifo

// [sep_master_model.sv]
module sep_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // The clock parks high and the data line is released between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Data falls while the clock is high.
    task automatic start();
        tick(1);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_low <= 1'b1;
        tick(3);
        scl <= 1'b0;
    endtask : start
    // Data changes only while the clock is low, so no false start or stop.
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_low <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(1);
        r = sda;
        tick(1);
        scl <= 1'b0;
    endtask : bit_io
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, r);
    endtask : rd_byte
    // Data rises while the clock is high.
    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        sda_low <= 1'b0;
        tick(4);
    endtask : stop
endmodule : sep_master_model

// [sep_slave_checker.sv]
module sep_slave_checker #(
    parameter int WRITE_CYCLES = sep_pkg::WR_CYCLES,
    parameter int FIFO_DEPTH   = sep_pkg::FIFO_DEPTH
) (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       scl,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       write_protect,
    input wire logic       chip_select_bit0,
    input wire logic       chip_select_bit1,
    input wire logic       chip_select_bit2,
    input wire logic [7:0] mem_rd_addr,
    input wire logic [7:0] mem_rd_data,
    input wire logic       prog_valid,
    input wire logic       prog_ready,
    input wire logic [7:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] busy_cnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Length of the running write cycle.
    always_ff @(posedge clk) begin
        if (srst || !busy) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    a_reset_quiet: assert property ($fell(srst) |-> !busy && !prog_valid && !sda_oe)
        else $error("outputs not idle after reset");
    a_busy_silent: assert property (busy |-> !sda_oe)
        else $error("bus answered during write cycle");
    a_busy_drained: assert property ($fell(busy) |-> !prog_valid)
        else $error("write cycle ended with bytes pending");
    a_cycle_length: assert property ($fell(busy) |-> busy_cnt_q >= 32'(WRITE_CYCLES - 1))
        else $error("write cycle too short");
    a_protect_no_cycle: assert property ($rose(busy) |-> !write_protect)
        else $error("write cycle while protected");
    a_protect_no_prog: assert property (write_protect |-> !prog_valid)
        else $error("program request while protected");
    a_prog_hold: assert property (prog_valid && !prog_ready |=>
        prog_valid && $stable(prog_addr) && $stable(prog_data))
        else $error("program request changed before taken");
    a_prog_page: assert property (prog_valid && prog_ready ##1 prog_valid |->
        prog_addr[7:4] == $past(prog_addr[7:4]))
        else $error("page write left its page");
    a_oe_clock_low: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("data line changed while clock high");
    c_cycle: cover property ($fell(busy));
    c_stall: cover property (prog_valid && !prog_ready);
    c_drive: cover property ($rose(sda_oe));
endmodule : sep_slave_checker
bind sep_slave sep_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (
    .clk(clk), .srst(srst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_protect(write_protect), .chip_select_bit0(chip_select_bit0),
    .chip_select_bit1(chip_select_bit1), .chip_select_bit2(chip_select_bit2),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy));

// [serial_eeprom_bus_slave_bench.sv]
module serial_eeprom_bus_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR = 300;
    logic       clk, srst, write_protect, prog_ready, scl, mst_low, sda_oe, sda_o;
    logic       prog_valid, busy, ack;
    logic [2:0] cs;
    logic [7:0] mem_rd_addr, mem_rd_data, prog_addr, prog_data, ptr, base;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    int         lens [5] = '{1, 16, 20, 7, 3};
    int         mismatches, compares;
    wire logic  sda_line;
    // Open-drain line with a pull-up.
    assign sda_line = ~((sda_oe & ~sda_o) | mst_low);
    assign mem_rd_data = mem[mem_rd_addr];
    sep_slave #(.WRITE_CYCLES(WR), .FIFO_DEPTH(sep_pkg::FIFO_DEPTH)) dut (
        .clk(clk), .srst(srst), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .write_protect(write_protect), .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
        .chip_select_bit2(cs[2]), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_addr(prog_addr),
        .prog_data(prog_data), .busy(busy));
    sep_master_model mst (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(mst_low));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // The array takes program requests with random stalls.
    always @(posedge clk) begin
        if (prog_valid === 1'b1 && prog_ready) mem[prog_addr] <= prog_data;
        prog_ready <= 1'($urandom);
    end
    task automatic close_out();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic send_addr(input logic [2:0] sel, input logic rd);
        mst.start();
        mst.wr_byte({sep_pkg::DEV_TYPE_ID, sel, rd}, ack);
    endtask : send_addr
    task automatic read_seq(input int n);
        logic [7:0] d;
        chk(ack, "read address ack");
        for (int i = 0; i < n; i++) begin
            mst.rd_byte(i < n - 1, d);
            chk(d === exp_mem[ptr], "read data");
            ptr = ptr + 8'h01;
        end
        mst.stop();
        repeat (4) @(posedge clk);
        chk(sda_oe === 1'b0, "line not released");
    endtask : read_seq
    task automatic rand_read(input logic [7:0] a, input int n);
        send_addr(cs, 1'b0);
        mst.wr_byte(a, ack);
        ptr = a;
        send_addr(cs, 1'b1);
        read_seq(n);
    endtask : rand_read
    // Next address inside the same 16-byte page.
    function automatic logic [7:0] page_next(input logic [7:0] a);
        return {a[7:4], a[3:0] + 4'h1};
    endfunction : page_next
    task automatic page_write(input logic [7:0] a, input int n);
        logic [7:0] d;
        int         k;
        send_addr(cs, 1'b0);
        chk(ack, "write address ack");
        mst.wr_byte(a, ack);
        chk(ack, "word address ack");
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mst.wr_byte(d, ack);
            chk(ack === ~write_protect, "data ack");
            if (!write_protect) begin
                exp_mem[a] = d;
                a = page_next(a);
            end
        end
        mst.stop();
        repeat (2) @(posedge clk);
        chk(busy === ~write_protect, "write cycle start");
        k = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && k < 20) begin
            send_addr(cs, 1'b0);
            mst.stop();
            if (k == 0) chk(ack === write_protect, "first poll");
            k++;
        end
        chk(ack, "poll never acked");
        ptr = a;
    endtask : page_write
    initial begin
        void'($urandom(32'hc5f2));
        foreach (mem[i]) begin
            mem[i] = 8'($urandom);
            exp_mem[i] = mem[i];
        end
        srst = 1'b1;
        write_protect = 1'b0;
        cs = 3'($urandom);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        // Every other select value is refused.
        for (int k = 1; k < 8; k++) begin
            send_addr(cs ^ 3'(k), 1'b0);
            mst.stop();
            chk(ack === 1'b0, "foreign select acked");
        end
        // Byte, full, overrun and short pages, then a protected one.
        for (int i = 0; i < 5; i++) begin
            base = 8'($urandom);
            cs <= 3'($urandom);
            write_protect <= (i == 4);
            @(posedge clk);
            page_write(base, lens[i]);
            if (i < 4) begin
                send_addr(cs, 1'b1);
                read_seq(1);
            end
            rand_read({base[7:4], 4'h0}, 16);
        end
        write_protect <= 1'b0;
        rand_read(8'hfd, 6);
        send_addr(cs, 1'b1);
        read_seq(2);
        close_out();
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
endmodule : serial_eeprom_bus_slave_bench
